/* File: hdl/lock_guard.sv */
// Purpose: decode one two-bit section lock field
// Assumes: 1 means unprogrammed
// Notes:   pure combinational
`timescale 1ns/1ps
module lock_guard (
    input  spm_ctrl_pkg::lock_field_t  field,
    output logic                       store_block,
    output logic                       load_block,
    output logic                       irq_mode
);
    import spm_ctrl_pkg::*;

    // 11 free, 10 store, 00 store and load, 01 load
    always_comb begin
        store_block = !field[0];
        load_block  = !field[1];
        irq_mode    = !field[1];
    end
endmodule

/* File: hdl/page_buffer.sv */
// Purpose: temporary page buffer, one page of 16-bit words
// Assumes: one write port, one read port read by the flash array
// Notes:   cleared words read back as erased value
`timescale 1ns/1ps
`include "spm_ctrl_regs.svh"
module page_buffer (
    input  wire logic                   core_clk,
    input  wire logic                   rst_n,
    input  wire logic                   clear,
    input  wire logic                   wr_en,
    input  wire logic [`PAGE_BITS-1:0]  wr_addr,
    input  wire logic [15:0]            wr_data,
    input  wire logic [`PAGE_BITS-1:0]  rd_addr,
    output logic      [15:0]            rd_data_r
);
    logic [15:0]             mem [`PAGE_WORDS];
    logic [`PAGE_WORDS-1:0]  valid_r;

    // ****
    // per-word valid flags
    // ****
    genvar i;
    generate
        for (i = 0; i < `PAGE_WORDS; i++) begin : g_valid
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    valid_r[i] <= 1'b0;
                end else if (clear) begin
                    valid_r[i] <= 1'b0;
                end else if (wr_en && (wr_addr == i)) begin
                    valid_r[i] <= 1'b1;
                end
            end
        end
    endgenerate

    // storage, no reset needed behind valid flags
    always_ff @(posedge core_clk) begin
        if (wr_en && !clear) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read, erased value for empty words
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 16'hFFFF;
        end else if (valid_r[rd_addr]) begin
            rd_data_r <= mem[rd_addr];
        end else begin
            rd_data_r <= 16'hFFFF;
        end
    end
endmodule

/* File: hdl/spm_ctrl.sv */
// Purpose: self-programming sequencer, control register, lock guards
// Assumes: core gives store/load pulses with pointer and data pair
// Notes:   lock bits live in nonvolatile store outside; only AND-programmed
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "spm_ctrl_regs.svh"
module spm_ctrl (
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // register port
    input  wire logic [3:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata_r,
    // core side
    input  wire logic                  store_req,
    input  wire logic                  load_req,
    input  wire logic                  exec_in_boot,
    input  wire logic                  vectors_in_boot,
    input  wire logic                  global_int_en,
    input  wire logic [15:0]           z_ptr,
    input  wire logic [15:0]           data_register_pair,
    output logic                       ready_irq_r,
    output logic                       irq_block_r,
    output logic                       core_halt_r,
    output logic                       load_grant_r,
    output logic                       load_deny_r,
    output logic                       load_data_valid_r,
    output logic      [7:0]            load_data_r,
    output logic      [11:0]           reset_vector_r,
    // nonvolatile lock and fuse store
    input  wire logic [5:0]            nv_lock,
    input  wire logic [7:0]            fuse_bits,
    input  wire logic                  reset_vector_fuse,
    output logic                       lock_prog_r,
    output logic      [5:0]            lock_prog_data_r,
    // flash array
    input  wire logic                  flash_done,
    input  wire logic [`PAGE_BITS-1:0] flash_buf_addr,
    output logic      [15:0]           flash_buf_data_r,
    output logic                       flash_erase_r,
    output logic                       flash_write_r,
    output logic      [6:0]            flash_page_r
);
    import spm_ctrl_pkg::*;

    // ****
    // declarations
    // ****
    seq_state_t   state_r;
    logic         ie_r;
    logic         section_busy_flag_r;
    logic [4:0]   cmd_r;
    logic [2:0]   win_cnt_r;
    logic         busy_no_read_while_write_section_r;
    logic         busy_write_r;
    logic [11:0]  word_addr;
    logic         tgt_boot;
    logic         tgt_no_read_while_write_section;
    logic         ctrl_wr;
    logic         cmd_ok;
    logic         store_go;
    logic         win_last;
    logic         store_denied;
    logic         start_prog;
    logic         buf_clear;
    logic         buf_fill;
    logic         app_sblk;
    logic         app_lblk;
    logic         app_irq;
    logic         boot_sblk;
    logic         boot_lblk;
    logic         boot_irq;
    logic         load_lockread;
    logic         load_blocked;

    // ****
    // address and command decode
    // ****
    function automatic logic valid_cmd(input logic [4:0] c);
        valid_cmd = (c == `CMD_RDEN) || (c == `CMD_LSET) ||
                    (c == `CMD_PW) || (c == `CMD_PE) || (c == `CMD_FILL);
    endfunction

    function automatic logic in_boot(input logic [11:0] a);
        in_boot = (a >= `BOOT_START);
    endfunction

    // pointer holds a byte address, flash is word organised
    assign word_addr = z_ptr[12:1];
    assign tgt_boot  = in_boot(word_addr);
    assign tgt_no_read_while_write_section  = (word_addr >= `NO_READ_WHILE_WRITE_SECTION_START);

    // no general lock mode input
    // RL2
    lock_guard u_app_guard (
        .field       ({nv_lock[`LK_APP_HI-1], nv_lock[`LK_APP_LO-1]}),
        .store_block (app_sblk),
        .load_block  (app_lblk),
        .irq_mode    (app_irq)
    );
    // RL3

    lock_guard u_boot_guard (
        .field       ({nv_lock[`LK_BOOT_HI-1], nv_lock[`LK_BOOT_LO-1]}),
        .store_block (boot_sblk),
        .load_block  (boot_lblk),
        .irq_mode    (boot_irq)
    );
    // RL5

    // accepted pattern, not busy
    assign ctrl_wr = reg_wr && (reg_addr == `CTRL_ADDR);
    assign cmd_ok  = ctrl_wr && valid_cmd(reg_wdata[4:0])
                     && (state_r != ST_BUSY); // RL20 RL12

    // store in window, boot code only
    assign store_go = (state_r == ST_ARMED) && store_req
                      && exec_in_boot; // RL22
    assign win_last = (win_cnt_r == `WINDOW_CYCLES - 3'h1);

    // lock check for erase and write targets
    assign store_denied = tgt_boot ? boot_sblk : app_sblk; // RL3 RL5

    assign start_prog = store_go && !store_denied
                        && (cmd_r[`B_PE] || cmd_r[`B_PW]);

    // buffer clears
    assign buf_clear = (cmd_ok && reg_wdata[`B_RDEN]) // RL13
                       || (store_go && cmd_r[`B_RDEN]) // RL24
                       || (state_r == ST_BUSY && flash_done
                           && busy_write_r); // RL24
    assign buf_fill  = store_go && (cmd_r == `CMD_FILL);

    // ****
    // page buffer
    // ****
    page_buffer u_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .clear     (buf_clear),
        .wr_en     (buf_fill),
        .wr_addr   (word_addr[`PAGE_BITS-1:0]), // RL18
        .wr_data   (data_register_pair),
        .rd_addr   (flash_buf_addr),
        .rd_data_r (flash_buf_data_r)
    );

    // ****
    // sequencer and enable window
    // ****
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= ST_IDLE;
            win_cnt_r <= 3'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_ok) begin
                        state_r   <= ST_ARMED;
                        win_cnt_r <= 3'h0; // RL25
                    end
                end
                ST_ARMED: begin
                    if (cmd_ok) begin
                        win_cnt_r <= 3'h0;
                    end else if (start_prog) begin
                        state_r <= ST_BUSY; // RL19
                    end else if (store_go || win_last) begin
                        state_r <= ST_IDLE; // RL19 RL25
                    end else begin
                        win_cnt_r <= win_cnt_r + 3'h1;
                    end
                end
                ST_BUSY: begin
                    if (flash_done) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // command bits: set by write, all drop together at end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= 5'h00;
        end else if (cmd_ok) begin
            cmd_r <= reg_wdata[4:0];
        end else if (state_r == ST_ARMED && !start_prog
                     && (store_go || win_last)) begin
            cmd_r <= 5'h00; // RL14 RL19 RL25
        end else if (state_r == ST_BUSY && flash_done) begin
            cmd_r <= 5'h00; // RL16 RL17
        end
    end

    // interrupt enable bit, writable at any time
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_r <= 1'b0;
        end else if (ctrl_wr) begin
            ie_r <= reg_wdata[`B_IE];
        end
    end

    // ****
    // programming launch and section busy
    // ****
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flash_erase_r <= 1'b0;
            flash_write_r <= 1'b0;
            flash_page_r  <= 7'h00;
        end else begin
            flash_erase_r <= start_prog && cmd_r[`B_PE]; // RL17
            flash_write_r <= start_prog && cmd_r[`B_PW]; // RL16
            if (start_prog) begin
                flash_page_r <= word_addr[11:`PAGE_BITS];
            end
        end
    end

    // target kind latched for the whole operation
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_no_read_while_write_section_r  <= 1'b0;
            busy_write_r <= 1'b0;
        end else if (start_prog) begin
            busy_no_read_while_write_section_r  <= tgt_no_read_while_write_section;
            busy_write_r <= cmd_r[`B_PW];
        end
    end

    // halt for no_read_while_write_section target until done
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_halt_r <= 1'b0;
        end else if (start_prog && tgt_no_read_while_write_section) begin
            core_halt_r <= 1'b1; // RL23 RL16 RL17
        end else if (flash_done) begin
            core_halt_r <= 1'b0;
        end
    end

    // busy flag: set wins over clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            section_busy_flag_r <= 1'b0;
        end else if (start_prog && !tgt_no_read_while_write_section) begin
            section_busy_flag_r <= 1'b1; // RL10
        end else if (store_go && cmd_r[`B_RDEN]) begin
            section_busy_flag_r <= 1'b0; // RL11 RL12
        end else if (buf_fill) begin
            section_busy_flag_r <= 1'b0; // RL11
        end
    end

    // ****
    // lock programming, only ever clears bits
    // ****
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_prog_r      <= 1'b0;
            lock_prog_data_r <= 6'h3F;
        end else begin
            lock_prog_r <= store_go && (cmd_r == `CMD_LSET); // RL14
            if (store_go && (cmd_r == `CMD_LSET)) begin
                lock_prog_data_r <= nv_lock & data_register_pair[5:0]; // RL1
            end
        end
    end

    // ****
    // program-memory loads
    // ****
    assign load_lockread = (state_r == ST_ARMED) && (cmd_r == `CMD_LSET)
                           && (win_cnt_r < `LOAD_CYCLES); // RL15

    // busy or locked loads denied
    assign load_blocked = (section_busy_flag_r && !tgt_no_read_while_write_section) // RL10
                          || (exec_in_boot && !tgt_boot && app_lblk) // RL3
                          || (!exec_in_boot && tgt_boot && boot_lblk); // RL5

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_grant_r      <= 1'b0;
            load_deny_r       <= 1'b0;
            load_data_valid_r <= 1'b0;
            load_data_r       <= 8'h00;
        end else begin
            load_data_valid_r <= load_req && load_lockread;
            load_grant_r      <= load_req && !load_lockread && !load_blocked;
            load_deny_r       <= load_req && !load_lockread && load_blocked;
            if (load_req && load_lockread) begin
                load_data_r <= z_ptr[0] ? fuse_bits
                                        : {2'b11, nv_lock}; // RL15
            end
        end
    end

    // ****
    // interrupts and reset vector
    // ****
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_irq_r <= 1'b0;
            irq_block_r <= 1'b0;
        end else begin
            ready_irq_r <= ie_r && global_int_en && !cmd_r[`B_SE]; // RL9
            irq_block_r <= (app_irq && vectors_in_boot && !exec_in_boot) // RL4
                           || (boot_irq && !vectors_in_boot
                               && exec_in_boot); // RL6
        end
    end

    // fuse is only an input; no register path writes it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_vector_r <= `APP_RESET;
        end else begin
            reset_vector_r <= reset_vector_fuse ? `APP_RESET
                                                : `BOOT_START; // RL7 RL8
        end
    end

    // ****
    // register read port
    // ****
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= `CTRL_RESET;
        end else if (reg_rd && reg_addr == `CTRL_ADDR) begin
            reg_rdata_r <= {ie_r, section_busy_flag_r,
                            1'b0, cmd_r}; // RL21
        end else if (reg_rd && reg_addr == `STAT_ADDR) begin
            reg_rdata_r <= {core_halt_r, (state_r == ST_BUSY), nv_lock};
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end
endmodule

/* File: hdl/spm_ctrl_pkg.sv */
// Purpose: shared types of the self-programming controller
// Assumes: nothing
// Notes:   one-hot sequencer states
package spm_ctrl_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_BUSY  = 3'b100
    } seq_state_t;

    typedef logic [1:0] lock_field_t;

endpackage

/* File: hdl/spm_ctrl_regs.svh */
// Purpose: register map, field positions, reset values and counts
// Assumes: 8-bit register port, 16-bit core data pair
// Notes:   offsets and lock bit positions are local choices
//
// Notes on behaviour
// RL1 - lock fields only ever programmed here; clearing needs full chip erase.
// RL2 - general memory lock modes never restrict stores or loads here.
// RL3 - app lock: 11 free, 10 no store, 00 no store/no boot load, 01 no load.
// RL4 - app modes 3/4 with boot vectors block interrupts in app code.
// RL5 - boot lock: 11 free, 10 no store, 00 no store/no app load, 01 no load.
// RL6 - boot modes 3/4 with app vectors block interrupts in boot code.
// RL7 - reset vector fuse 1 starts at 0x0000, 0 at boot start.
// RL8 - running program has no path to alter fuses.
// RL9 - ready interrupt requested while enable and global flag set, store off.
// RL10 - erase or write to the busy section sets busy flag, blocks it.
// RL11 - busy flag clears on read-enable after programming or buffer load.
// RL12 - read-enable reopens section only when no erase or write is busy.
// RL13 - read-enable written during buffer loading discards loaded data.
// RL14 - lock-set store programs lock bits from low data, times out.
// RL15 - load within three cycles of lock-set returns lock or fuse bits.
// RL16 - page-write store programs buffer into pointer page, halts on no_read_while_write_section.
// RL17 - page-erase store erases pointer page, halts core on no_read_while_write_section target.
// RL18 - store-enable alone stores data pair into buffer word at pointer.
// RL19 - store-enable clears on store or after four cycles, holds while busy.
// RL20 - only five command patterns accepted; others have no effect.
// RL21 - bit 5 of the control register always reads zero.
// RL22 - stores start programming only when executed from the boot section.
// RL23 - no_read_while_write_section target halts core whole operation; rww target leaves reads.
// RL24 - page buffer clears after page write, read-enable and reset.
// RL25 - window counts from the write; all command bits drop on expiry.
`ifndef SPM_CTRL_REGS_SVH
`define SPM_CTRL_REGS_SVH

// ****
// register offsets
// ****
`define CTRL_ADDR       4'h0
`define STAT_ADDR       4'h1
`define CTRL_RESET      8'h00

// ****
// control register fields
// ****
`define B_IE            7
`define B_BUSY          6
`define B_RES           5
`define B_RDEN          4
`define B_LSET          3
`define B_PW            2
`define B_PE            1
`define B_SE            0

// ****
// command patterns in the low five bits
// ****
`define CMD_RDEN        5'h11
`define CMD_LSET        5'h09
`define CMD_PW          5'h05
`define CMD_PE          5'h03
`define CMD_FILL        5'h01

// ****
// timing counts in core cycles
// ****
`define WINDOW_CYCLES   3'h4
`define LOAD_CYCLES     3'h3

// ****
// flash geometry and lock bit positions in low data
// ****
`define PAGE_WORDS      32
`define PAGE_BITS       5
`define BOOT_START      12'hC00
`define NO_READ_WHILE_WRITE_SECTION_START      12'hC00
`define APP_RESET       12'h000
`define LK_APP_LO       1
`define LK_APP_HI       2
`define LK_BOOT_LO      3
`define LK_BOOT_HI      4

`endif

/* File: verif/flash_model.sv */
// Purpose: flash array stand-in finishing erase and write
// Assumes: erase and write arrive as one-cycle pulses
// Notes:   busy time is a parameter, not the array timing
`timescale 1ns/1ps
module flash_model #(
    parameter int DONE_DLY = 20
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic flash_erase_r,
    input  wire logic flash_write_r,
    output logic      flash_done
);
    int cnt;
    // count the programming time, then pulse done once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (cnt == 1);
            if (flash_erase_r || flash_write_r)
                cnt <= DONE_DLY;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule

/* File: verif/spm_ctrl_asserts.sv */
// Purpose: port assertions for the self-programming controller
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every spm_ctrl instance below
`timescale 1ns/1ps
`include "spm_ctrl_regs.svh"
module spm_ctrl_asserts (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata_r,
    input wire logic        store_req,
    input wire logic        load_req,
    input wire logic        exec_in_boot,
    input wire logic        global_int_en,
    input wire logic [15:0] z_ptr,
    input wire logic [15:0] data_register_pair,
    input wire logic        ready_irq_r,
    input wire logic        core_halt_r,
    input wire logic        load_grant_r,
    input wire logic        load_deny_r,
    input wire logic        load_data_valid_r,
    input wire logic [5:0]  nv_lock,
    input wire logic        reset_vector_fuse,
    input wire logic [11:0] reset_vector_r,
    input wire logic        lock_prog_r,
    input wire logic [5:0]  lock_prog_data_r,
    input wire logic        flash_done,
    input wire logic        flash_erase_r,
    input wire logic        flash_write_r,
    input wire logic [6:0]  flash_page_r
);
    logic [6:0] zpage;
    logic [5:0] dlo;
    // pointer page and lock data
    assign zpage = z_ptr[12:6];
    assign dlo   = data_register_pair[5:0];
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // erase command written
    sequence arm_erase;
        reg_wr && reg_addr == `CTRL_ADDR && reg_wdata[4:0] == `CMD_PE;
    endsequence
    res_zero_a: assert property (
        $past(reg_rd) && $past(reg_addr) == `CTRL_ADDR |-> !reg_rdata_r[5])
        else $error("reserved bit set");
    op_cause_a: assert property (
        flash_erase_r || flash_write_r
        |-> $past(store_req) && $past(exec_in_boot))
        else $error("op without boot store");
    page_sel_a: assert property (
        flash_erase_r || flash_write_r |-> flash_page_r == $past(zpage))
        else $error("bad page");
    halt_hold_a: assert property (
        core_halt_r && !flash_done |=> core_halt_r)
        else $error("halt dropped");
    halt_cause_a: assert property (
        $rose(core_halt_r) |-> flash_erase_r || flash_write_r)
        else $error("halt without op");
    lock_and_a: assert property (
        lock_prog_r |-> lock_prog_data_r == ($past(nv_lock) & $past(dlo)))
        else $error("lock bits raised");
    rst_vec_a: assert property (
        $past(rst_n) |-> reset_vector_r ==
        ($past(reset_vector_fuse) ? 12'h000 : `BOOT_START))
        else $error("bad reset vector");
    irq_gate_a: assert property (
        ready_irq_r |-> $past(global_int_en))
        else $error("irq without global enable");
    load_ans_a: assert property (
        load_req |=> $onehot({load_grant_r, load_deny_r, load_data_valid_r}))
        else $error("bad load answer");
    lapse_a: assert property (
        arm_erase ##1 (!store_req && !reg_wr) [*4] ##1 store_req
        |=> !flash_erase_r)
        else $error("late store taken");
endmodule
bind spm_ctrl spm_ctrl_asserts u_chk (.*);

/* File: verif/tb_spm_ctrl.sv */
// Purpose: directed bench for the self-programming controller
// Assumes: register port answers one cycle after the read strobe
// Notes:   bench plays core, lock store and buffer reader
`timescale 1ns/1ps
`include "spm_ctrl_regs.svh"
module tb_spm_ctrl;
    logic        core_clk, rst_n, reg_wr, reg_rd, store_req, load_req;
    logic        exec_in_boot, vectors_in_boot, global_int_en, flash_done;
    logic        reset_vector_fuse, ready_irq_r, irq_block_r, core_halt_r;
    logic        load_grant_r, load_deny_r, load_data_valid_r, lock_prog_r;
    logic        flash_erase_r, flash_write_r;
    logic [3:0]  reg_addr;
    logic [4:0]  flash_buf_addr;
    logic [5:0]  nv_lock, lock_prog_data_r;
    logic [6:0]  flash_page_r;
    logic [7:0]  reg_wdata, reg_rdata_r, load_data_r, fuse_bits;
    logic [11:0] reset_vector_r;
    logic [15:0] z_ptr, data_register_pair, flash_buf_data_r;
    logic [7:0]  p [7] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h11, 8'h07, 8'h13};
    int          n_errors = 0;
    int          n_checks = 0;

    spm_ctrl DUT (.*);
    flash_model u_flash (.*);

    // free-running core clock
    always #5 core_clk = ~core_clk;

    // ****
    // access tasks
    // ****
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask
    task automatic op(input logic [3:0] k);
        {reg_wr, reg_rd, store_req, load_req} <= k;
        tick;
    endtask
    task automatic idle(input int n);
        repeat (n) op(4'h0);
    endtask
    task automatic chk(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        reg_addr <= `CTRL_ADDR;
        reg_wdata <= d;
        op(4'h8);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input string s);
        reg_addr <= a;
        op(4'h4);
        chk(s, e, reg_rdata_r);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // poll until store enable drops, bounded
    task automatic wait_se;
        int k;
        reg_addr <= `CTRL_ADDR;
        for (k = 0; k < 100; k++) begin
            op(4'h4);
            if (reg_rdata_r[0] === 1'b0) break;
        end
        if (k == 100) begin
            n_errors++;
            $display("CHECK FAILED store enable expected 0 seen 1");
            give_verdict;
        end
    endtask

    // main sequence
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {reg_wr, reg_rd, store_req, load_req, vectors_in_boot} = '0;
        {global_int_en, reg_addr, reg_wdata, z_ptr, flash_buf_addr} = '0;
        data_register_pair = 16'h0000;
        {exec_in_boot, reset_vector_fuse} = 2'b11;
        nv_lock = 6'h3F;
        fuse_bits = 8'hA5;
        repeat (2) tick;
        rst_n = 1'b1;
        tick;
        rd(`CTRL_ADDR, 8'h00, "ctrl reset");
        rd(4'hF, 8'h00, "unmapped read");
        chk("reset vector", 16'h0000, reset_vector_r);
        $display("test reset done");
        foreach (p[j]) begin
            wr(p[j]);
            rd(`CTRL_ADDR, j < 5 ? p[j] : 8'h00, "command");
            idle(5);
            rd(`CTRL_ADDR, 8'h00, "window lapse");
        end
        $display("test commands done");
        global_int_en <= 1'b1;
        wr(8'hE0);
        rd(`CTRL_ADDR, 8'h80, "reserved bit");
        chk("ready irq", 16'h0001, ready_irq_r);
        wr(8'h81);
        op(4'h0);
        chk("irq while armed", 16'h0000, ready_irq_r);
        idle(5);
        chk("irq after lapse", 16'h0001, ready_irq_r);
        wr(8'h00);
        $display("test interrupt done");
        z_ptr <= 16'h0040;
        wr(8'h03);
        idle(4);
        op(4'h2);
        chk("late erase", 16'h0000, flash_erase_r);
        wr(8'h03);
        op(4'h2);
        chk("erase pulse", 16'h0001, flash_erase_r);
        chk("erase page", 16'h0001, flash_page_r);
        op(4'h1);
        chk("busy load", 16'h0001, load_deny_r);
        wr(8'h11);
        rd(`CTRL_ADDR, 8'h43, "busy ctrl");
        wait_se;
        rd(`CTRL_ADDR, 8'h40, "busy kept");
        wr(8'h11);
        op(4'h2);
        op(4'h0);
        rd(`CTRL_ADDR, 8'h00, "reopened");
        $display("test erase done");
        flash_buf_addr <= 5'd1;
        z_ptr <= 16'h0003;
        data_register_pair <= 16'hC3A5;
        wr(8'h01);
        op(4'h2);
        idle(3);
        chk("buffer word", 16'hC3A5, flash_buf_data_r);
        exec_in_boot <= 1'b0;
        data_register_pair <= 16'h1111;
        wr(8'h01);
        op(4'h2);
        idle(3);
        chk("app store", 16'hC3A5, flash_buf_data_r);
        exec_in_boot <= 1'b1;
        z_ptr <= 16'h1800;
        wr(8'h05);
        op(4'h2);
        chk("halt", 16'h0001, core_halt_r);
        chk("write page", 16'h0060, flash_page_r);
        wait_se;
        chk("halt end", 16'h0000, core_halt_r);
        chk("buffer clear", 16'hFFFF, flash_buf_data_r);
        $display("test write done");
        z_ptr <= 16'h0000;
        data_register_pair <= 16'h00FB;
        wr(8'h09);
        op(4'h2);
        chk("lock pulse", 16'h0001, lock_prog_r);
        chk("lock data", 16'h003B, lock_prog_data_r);
        // lock store now also has the application field at 10
        nv_lock <= 6'h3A;
        wr(8'h09);
        op(4'h1);
        chk("lock readback", 16'h00FA, load_data_r);
        z_ptr <= 16'h0001;
        wr(8'h09);
        op(4'h1);
        chk("fuse readback", 16'h00A5, load_data_r);
        z_ptr <= 16'h0040;
        wr(8'h03);
        op(4'h2);
        chk("locked erase", 16'h0000, flash_erase_r);
        {nv_lock, vectors_in_boot, exec_in_boot} <= 8'hE2;
        op(4'h1);
        chk("irq block", 16'h0001, irq_block_r);
        chk("app load", 16'h0001, load_grant_r);
        idle(2);
        $display("test locks done");
        give_verdict;
    end
endmodule
